// ===== verilog/tmr_pair_pkg.sv
// constants, register map and field layouts of the timer pair
// assumes an apb master with 32-bit data; each 16-bit register sits in the low
// half of its own word
//
// Contract
// - 32-bit match pulses adc trigger from upper
// - prescaler divides by 1, 8, 64, 256
// - 32-bit mode counts on lower clock, prescaler
// - count write, enable clear, reset clear prescaler
// - disabled lower timer does not reset prescaler
// - control write leaves count unchanged
// - no counting during cpu sleep
// - 32-bit match or gate fall sets flag
// - bit 7 enable gates 32-bit interrupt
// - holding register at index 0108
// - unimplemented bits read as zero
// - 32-bit count wraps to zero after match
// - lower count read latches upper into holding
// - joined lower count write loads upper from holding
// - join bit selects 32-bit; upper control ignored
package tmr_pair_pkg;

   // ------------------------------------------------------------
   // register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_LOWER_COUNT   = 10'h106;
   localparam logic [9:0] IDX_UPPER_HOLDING = 10'h108;
   localparam logic [9:0] IDX_UPPER_COUNT   = 10'h10A;
   localparam logic [9:0] IDX_LOWER_PERIOD  = 10'h10C;
   localparam logic [9:0] IDX_UPPER_PERIOD  = 10'h10E;
   localparam logic [9:0] IDX_LOWER_CONTROL = 10'h110;
   localparam logic [9:0] IDX_UPPER_CONTROL = 10'h112;
   localparam logic [9:0] IDX_IRQ_FLAG      = 10'h120;
   localparam logic [9:0] IDX_IRQ_ENABLE    = 10'h122;

   // ------------------------------------------------------------
   // reset values, masks and bit positions
   // ------------------------------------------------------------
   localparam logic [15:0] PERIOD_RESET    = 16'hFFFF;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
   localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;
   localparam logic [15:0] IRQ_MASK        = 16'h00C0;
   localparam int unsigned FLAG_LOWER_BIT  = 6;
   localparam int unsigned FLAG_UPPER_BIT  = 7;

   // prescaler terminal counts for 1, 8, 64 and 256
   localparam logic [7:0] PSC_LIM_1   = 8'h00;
   localparam logic [7:0] PSC_LIM_8   = 8'h07;
   localparam logic [7:0] PSC_LIM_64  = 8'h3F;
   localparam logic [7:0] PSC_LIM_256 = 8'hFF;

   // control register layout
   typedef struct packed {
      logic       timer_on;
      logic       rsv14;
      logic       stop_in_idle;
      logic [5:0] rsv12_7;
      logic       gated_accumulate;
      logic [1:0] prescale_select;
      logic       join_32bit;
      logic       rsv2;
      logic       clock_source_select;
      logic       rsv0;
   } ctrl_t;

   // apb request as seen by the slave
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage

// ===== verilog/tmr_pair.sv
// timer pair: two 16-bit timers, optionally joined into one 32-bit timer
// assumes apb3 master on pclk; sleep, idle and the gate/clock pin are
// synchronous to pclk; pin levels must stand one pclk each or edges are lost
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module tmr_pair (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire tmr_pair_pkg::apb_req_t apb_req,
   output var  logic [31:0]            prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   input  wire logic                   gate_clk_in,
   input  wire logic                   cpu_sleep,
   input  wire logic                   cpu_idle,
   output var  logic                   adc_trigger,
   output var  logic                   irq
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // terminal count of the prescaler for a divide setting
   function automatic logic [7:0] psc_limit(input logic [1:0] sel);
      logic [7:0] lim;
      lim = tmr_pair_pkg::PSC_LIM_1;
      unique case (sel)
         2'h0: lim = tmr_pair_pkg::PSC_LIM_1;
         2'h1: lim = tmr_pair_pkg::PSC_LIM_8;
         2'h2: lim = tmr_pair_pkg::PSC_LIM_64;
         2'h3: lim = tmr_pair_pkg::PSC_LIM_256;
      endcase
      return lim;
   endfunction

   // registers are word aligned; the two low address bits are ignored
   function automatic logic is_reg(input logic [11:0] addr, input logic [9:0] idx);
      return addr[11:2] == idx;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // index 0 is the lower timer, index 1 the upper one
   tmr_pair_pkg::ctrl_t [1:0] ctl_q;
   logic [1:0][15:0]          cnt_q;
   logic [1:0][15:0]          cnt_d;
   logic [1:0][15:0]          per_q;
   logic [1:0][7:0]           psc_q;
   logic [15:0]               hold_q;
   logic [15:0]               flag_q;
   logic [15:0]               flag_d;
   logic [15:0]               ien_q;
   logic                      gate_q;
   logic [31:0]               prdata_q;
   logic                      pready_q;
   logic                      pslverr_q;
   logic                      adc_q;
   logic                      irq_q;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic        access;
   logic        done;
   logic        wr_done;
   logic        rd_done;
   logic [11:0] addr;
   logic [15:0] wdata;
   logic        mapped;
   logic        joined;
   // written word seen as a control register, for its field names
   tmr_pair_pkg::ctrl_t wctl;

   // a transfer takes effect at the edge that completes its access phase
   assign access  = apb_req.psel && apb_req.penable;
   assign done    = access && pready_q;
   assign wr_done = done && apb_req.pwrite && mapped;
   assign rd_done = done && !apb_req.pwrite && mapped;
   assign addr    = apb_req.paddr;
   assign wdata   = apb_req.pwdata[15:0];
   assign wctl    = wdata;
   assign joined  = ctl_q[0].join_32bit;

   always_comb begin
      mapped = is_reg(addr, tmr_pair_pkg::IDX_LOWER_COUNT)
            || is_reg(addr, tmr_pair_pkg::IDX_UPPER_HOLDING)
            || is_reg(addr, tmr_pair_pkg::IDX_UPPER_COUNT)
            || is_reg(addr, tmr_pair_pkg::IDX_LOWER_PERIOD)
            || is_reg(addr, tmr_pair_pkg::IDX_UPPER_PERIOD)
            || is_reg(addr, tmr_pair_pkg::IDX_LOWER_CONTROL)
            || is_reg(addr, tmr_pair_pkg::IDX_UPPER_CONTROL)
            || is_reg(addr, tmr_pair_pkg::IDX_IRQ_FLAG)
            || is_reg(addr, tmr_pair_pkg::IDX_IRQ_ENABLE);
   end

   // per-timer write strobes for count and control
   logic [1:0] wr_cnt;
   logic [1:0] wr_ctl;
   assign wr_cnt[0] = wr_done && is_reg(addr, tmr_pair_pkg::IDX_LOWER_COUNT);
   assign wr_cnt[1] = wr_done && is_reg(addr, tmr_pair_pkg::IDX_UPPER_COUNT);
   assign wr_ctl[0] = wr_done && is_reg(addr, tmr_pair_pkg::IDX_LOWER_CONTROL);
   assign wr_ctl[1] = wr_done && is_reg(addr, tmr_pair_pkg::IDX_UPPER_CONTROL);

   // ------------------------------------------------------------
   // clock sources and prescalers
   // ------------------------------------------------------------
   logic       gate_rise;
   logic       gate_fall;
   logic [1:0] run;
   logic [1:0] src_tick;
   logic [1:0] hit;
   logic [1:0] ton_clear;

   // gate_q resets low like the idle pin, so reset makes no false edge
   assign gate_rise = gate_clk_in && !gate_q;
   assign gate_fall = gate_q && !gate_clk_in;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // no clocks reach the timers in sleep
         run[i] = ctl_q[i].timer_on && !cpu_sleep
               && !(cpu_idle && ctl_q[i].stop_in_idle);
         // clearing timer_on restarts the division
         ton_clear[i] = wr_ctl[i] && ctl_q[i].timer_on
                     && !wctl.timer_on;
      end
      // only the lower timer has a pin; gate is ignored on the upper one
      if (ctl_q[0].clock_source_select) begin
         src_tick[0] = gate_rise;
      end else if (ctl_q[0].gated_accumulate) begin
         src_tick[0] = gate_clk_in;
      end else begin
         src_tick[0] = 1'b1;
      end
      src_tick[1] = !ctl_q[1].clock_source_select;
      for (int i = 0; i < 2; i++) begin
         hit[i] = run[i] && src_tick[i]
               && psc_q[i] == psc_limit(ctl_q[i].prescale_select);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc_q <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (ton_clear[i]) begin
               psc_q[i] <= '0;
            end else if (|wr_cnt && ctl_q[i].timer_on) begin
               // any count write restarts the division of each timer whose timer_on is set, even one stopped by sleep or idle
               psc_q[i] <= '0;
            end else if (run[i] && src_tick[i]) begin
               psc_q[i] <= hit[i] ? 8'h00 : psc_q[i] + 8'h01;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // counters
   // ------------------------------------------------------------
   // match_ev[1] is the upper or 32-bit match: trigger and upper flag
   logic [1:0] match_ev;

   always_comb begin
      cnt_d    = cnt_q;
      match_ev = '0;
      // joined: the halves act as one word; the upper prescaler is unused
      if (joined) begin
         if (hit[0]) begin
            if (cnt_q == per_q) begin
               cnt_d       = '0;
               match_ev[1] = 1'b1;
            end else begin
               cnt_d = cnt_q + 32'h0000_0001;
            end
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (hit[i]) begin
               if (cnt_q[i] == per_q[i]) begin
                  cnt_d[i]    = '0;
                  match_ev[i] = 1'b1;
               end else begin
                  cnt_d[i] = cnt_q[i] + 16'h0001;
               end
            end
         end
      end
      // a bus write wins over a tick in the same cycle
      if (wr_cnt[0]) begin
         cnt_d[0] = wdata;
         // only a joined pair reloads the upper half from holding
         if (joined) begin
            cnt_d[1] = hold_q;
         end
      end
      if (wr_cnt[1]) begin
         cnt_d[1] = wdata;
      end
   end

   // control writes never touch the counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= '0;
      end else if (rd_done && is_reg(addr, tmr_pair_pkg::IDX_LOWER_COUNT)) begin
         // snapshot as the read completes, one edge after prdata took the lower word
         hold_q <= cnt_q[1];
      end else if (wr_done && is_reg(addr, tmr_pair_pkg::IDX_UPPER_HOLDING)) begin
         hold_q <= wdata;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_q <= {tmr_pair_pkg::PERIOD_RESET, tmr_pair_pkg::PERIOD_RESET};
         ctl_q <= {tmr_pair_pkg::CTRL_RESET, tmr_pair_pkg::CTRL_RESET};
         ien_q <= '0;
      end else if (wr_done) begin
         if (is_reg(addr, tmr_pair_pkg::IDX_LOWER_PERIOD)) begin
            per_q[0] <= wdata;
         end
         if (is_reg(addr, tmr_pair_pkg::IDX_UPPER_PERIOD)) begin
            per_q[1] <= wdata;
         end
         if (wr_ctl[0]) begin
            ctl_q[0] <= wdata & tmr_pair_pkg::LOWER_CTRL_MASK;
         end
         if (wr_ctl[1]) begin
            ctl_q[1] <= wdata & tmr_pair_pkg::UPPER_CTRL_MASK;
         end
         // only the two flag bits exist in the enable register
         if (is_reg(addr, tmr_pair_pkg::IDX_IRQ_ENABLE)) begin
            ien_q <= wdata & tmr_pair_pkg::IRQ_MASK;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt flags and adc trigger
   // ------------------------------------------------------------
   logic [15:0] flag_set;
   logic [15:0] flag_clr;
   logic        gate_ev;

   // a gate fall goes to the flag of whichever mode is active
   assign gate_ev = gate_fall && ctl_q[0].timer_on && ctl_q[0].gated_accumulate
                 && !ctl_q[0].clock_source_select;

   always_comb begin
      flag_set = '0;
      flag_set[tmr_pair_pkg::FLAG_UPPER_BIT] = match_ev[1] || (joined && gate_ev);
      flag_set[tmr_pair_pkg::FLAG_LOWER_BIT] = match_ev[0] || (!joined && gate_ev);
      flag_clr = '0;
      if (wr_done && is_reg(addr, tmr_pair_pkg::IDX_IRQ_FLAG)) begin
         flag_clr = wdata & tmr_pair_pkg::IRQ_MASK;
      end
      // a new event wins over a clear in the same cycle
      flag_d = (flag_q & ~flag_clr) | flag_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= '0;
         irq_q  <= 1'b0;
      end else begin
         flag_q <= flag_d;
         // built from the next flags, so irq rises with the flag itself
         irq_q  <= |(flag_d & ien_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_q  <= 1'b0;
         gate_q <= 1'b0;
      end else begin
         // single-cycle pulse; a slow consumer must stretch it
         adc_q  <= match_ev[1];
         gate_q <= gate_clk_in;
      end
   end

   // ------------------------------------------------------------
   // apb read data and handshake (one wait state)
   // ------------------------------------------------------------
   // read data is captured in the wait cycle and stands while pready is high
   logic [15:0] rd_val;

   always_comb begin
      rd_val = '0;
      if (is_reg(addr, tmr_pair_pkg::IDX_LOWER_COUNT)) begin
         rd_val = cnt_q[0];
      end else if (is_reg(addr, tmr_pair_pkg::IDX_UPPER_HOLDING)) begin
         rd_val = hold_q;
      end else if (is_reg(addr, tmr_pair_pkg::IDX_UPPER_COUNT)) begin
         rd_val = cnt_q[1];
      end else if (is_reg(addr, tmr_pair_pkg::IDX_LOWER_PERIOD)) begin
         rd_val = per_q[0];
      end else if (is_reg(addr, tmr_pair_pkg::IDX_UPPER_PERIOD)) begin
         rd_val = per_q[1];
      end else if (is_reg(addr, tmr_pair_pkg::IDX_LOWER_CONTROL)) begin
         rd_val = ctl_q[0];
      end else if (is_reg(addr, tmr_pair_pkg::IDX_UPPER_CONTROL)) begin
         rd_val = ctl_q[1];
      end else if (is_reg(addr, tmr_pair_pkg::IDX_IRQ_FLAG)) begin
         rd_val = flag_q;
      end else if (is_reg(addr, tmr_pair_pkg::IDX_IRQ_ENABLE)) begin
         rd_val = ien_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         // exactly one wait state for every access; unmapped ones flag an error
         pready_q  <= access && !pready_q;
         pslverr_q <= access && !pready_q && !mapped;
         if (access && !pready_q && !apb_req.pwrite) begin
            prdata_q <= {16'h0000, rd_val};
         end
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign adc_trigger = adc_q;
   assign irq         = irq_q;

endmodule

`default_nettype wire

// ===== bench/tmr_pair_chk.sv
// concurrent checks on the timer pair's bus answer, trigger and interrupt pins
// assumes it is bound to tmr_pair and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none

module tmr_pair_chk (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire tmr_pair_pkg::apb_req_t apb_req,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   cpu_sleep,
   input wire logic                   adc_trigger,
   input wire logic                   irq
);
   logic mapped;

   assign mapped = apb_req.paddr[11:2] inside {tmr_pair_pkg::IDX_LOWER_COUNT,
      tmr_pair_pkg::IDX_UPPER_HOLDING, tmr_pair_pkg::IDX_UPPER_COUNT,
      tmr_pair_pkg::IDX_LOWER_PERIOD, tmr_pair_pkg::IDX_UPPER_PERIOD,
      tmr_pair_pkg::IDX_LOWER_CONTROL, tmr_pair_pkg::IDX_UPPER_CONTROL,
      tmr_pair_pkg::IDX_IRQ_FLAG, tmr_pair_pkg::IDX_IRQ_ENABLE};

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------
   chk_ready_wait: assert property (apb_req.psel && !apb_req.penable |=> !pready ##1 pready)
      else $error("pready not in second access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_ready_access: assert property (pready |-> apb_req.psel && apb_req.penable)
      else $error("pready outside an access phase");
   chk_err_unmapped: assert property (apb_req.psel && !apb_req.penable |-> ##2 pslverr == !mapped)
      else $error("pslverr does not follow the address map");
   chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("refused access not answered with zero");
   chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");

   // ----------------------------------------------------------
   // events
   // ----------------------------------------------------------
   // flags and enables only clear by a write; irq drops at the edge completing a flag write, an edge later after an enable write
   chk_irq_drop: assert property ($fell(irq) |-> $past(pready && apb_req.pwrite))
      else $error("irq dropped without a register write");
   chk_trig_awake: assert property (adc_trigger |-> !$past(cpu_sleep))
      else $error("trigger after a sleeping cycle");

   cover property (adc_trigger);
   cover property ($rose(irq));
   cover property (pslverr);
endmodule

`default_nettype wire

// ===== bench/tmr_pair_bench.sv
// self-checking bench for the timer pair: registers, counting, joining,
// sleep, gate and interrupt; assumes tmr_pair_chk is compiled first
`timescale 1ns/1ps
`default_nettype none

module tmr_pair_bench;
   logic                   pclk;
   logic                   presetn;
   tmr_pair_pkg::apb_req_t req;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic                   gate_clk_in;
   logic                   cpu_sleep;
   logic                   adc_trigger;
   logic                   irq;
   logic                   last_err;
   logic [31:0]            rd;
   logic [15:0]            lp;
   int                     num_errors;
   int                     n_checks;

   tmr_pair DUT (
      .pclk        (pclk),
      .presetn     (presetn),
      .apb_req     (req),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .gate_clk_in (gate_clk_in),
      .cpu_sleep   (cpu_sleep),
      .cpu_idle    (1'b0),
      .adc_trigger (adc_trigger),
      .irq         (irq)
   );

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // request held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [9:0] idx, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= w;
      req.paddr   <= {idx, 2'b00};
      req.pwdata  <= {16'h0000, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) num_errors++;
      rd = prdata;
      last_err = pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [15:0] d);
      xfer(1'b1, idx, d);
   endtask

   task automatic rdchk(input string name, input logic [9:0] idx, input logic [15:0] exp);
      xfer(1'b0, idx, 16'h0000);
      check(name, rd, {16'h0000, exp});
   endtask

   task automatic wait_for(ref logic sig, input int lim, input string name);
      int n;
      for (n = 0; n < lim && sig !== 1'b1; n++) @(posedge pclk);
      check(name, {31'h0, sig}, 32'h1);
   endtask

   // tolerance covers the few bus cycles around the wait
   function automatic logic in_range(input logic [15:0] c, input int ps);
      int d;
      case (ps)
         0: d = 1;
         1: d = 8;
         2: d = 64;
         default: d = 256;
      endcase
      return int'(c) >= 600 / d - 1 && int'(c) <= 608 / d + 1;
   endfunction

   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end

   // ----------------------------------------------------------
   // tests
   // ----------------------------------------------------------
   initial begin
      req = '0;
      presetn = 1'b0;
      gate_clk_in = 1'b0;
      cpu_sleep = 1'b0;
      num_errors = 0;
      n_checks = 0;
      void'($urandom(1));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("period reset", tmr_pair_pkg::IDX_UPPER_PERIOD, 16'hFFFF);
      rdchk("control reset", tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0000);
      xfer(1'b0, 10'h130, 16'h1234);
      check("unmapped", {rd[30:0], last_err}, 32'h0000_0001);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'hFFFF);
      rdchk("lower ctrl bits", tmr_pair_pkg::IDX_LOWER_CONTROL, 16'hA07A);
      wr(tmr_pair_pkg::IDX_UPPER_CONTROL, 16'hFFFF);
      rdchk("upper ctrl bits", tmr_pair_pkg::IDX_UPPER_CONTROL, 16'hA072);
      wr(tmr_pair_pkg::IDX_UPPER_CONTROL, 16'h0000);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0000);
      wr(tmr_pair_pkg::IDX_LOWER_COUNT, 16'h1234);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0030);
      rdchk("count kept", tmr_pair_pkg::IDX_LOWER_COUNT, 16'h1234);
      for (int ps = 3; ps >= 0; ps--) begin
         wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0000);
         wr(tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0000);
         wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h8000 | 16'(ps << 4));
         repeat (600) @(posedge pclk);
         xfer(1'b0, tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0000);
         check("prescaled count", {31'h0, in_range(rd[15:0], ps)}, 32'h1);
      end
      // a count write restarts the division: the next tick is eight cycles away
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h8010);
      repeat ($urandom_range(20, 3)) @(posedge pclk);
      wr(tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0000);
      repeat (5) @(posedge pclk);
      rdchk("no early tick", tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0000);
      rdchk("first tick", tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0001);
      cpu_sleep <= 1'b1;
      xfer(1'b0, tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0000);
      lp = rd[15:0];
      repeat (40) @(posedge pclk);
      rdchk("sleep hold", tmr_pair_pkg::IDX_LOWER_COUNT, lp);
      cpu_sleep <= 1'b0;
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0000);
      wr(tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0000);
      // external clock: one tick per sampled rising edge of the pin
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h8002);
      repeat (5) begin
         gate_clk_in <= 1'b1;
         repeat (2) @(posedge pclk);
         gate_clk_in <= 1'b0;
         repeat (2) @(posedge pclk);
      end
      rdchk("external edges", tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0005);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0000);
      wr(tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0000);
      lp = 16'(20 + $urandom_range(40));
      wr(tmr_pair_pkg::IDX_LOWER_PERIOD, lp);
      wr(tmr_pair_pkg::IDX_IRQ_ENABLE, 16'h0040);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h8000);
      wait_for(irq, int'(lp) + 20, "16-bit irq");
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0000);
      rdchk("flag sticky", tmr_pair_pkg::IDX_IRQ_FLAG, 16'h0040);
      wr(tmr_pair_pkg::IDX_IRQ_FLAG, 16'h0040);
      rdchk("flag cleared", tmr_pair_pkg::IDX_IRQ_FLAG, 16'h0000);
      check("irq low", {31'h0, irq}, 32'h0);
      wr(tmr_pair_pkg::IDX_UPPER_PERIOD, 16'(10 + $urandom_range(20)));
      wr(tmr_pair_pkg::IDX_UPPER_CONTROL, 16'h8000);
      wait_for(adc_trigger, 60, "upper 16-bit trigger");
      wr(tmr_pair_pkg::IDX_UPPER_CONTROL, 16'h0000);
      rdchk("upper flag", tmr_pair_pkg::IDX_IRQ_FLAG, 16'h0080);
      wr(tmr_pair_pkg::IDX_IRQ_FLAG, 16'h0080);
      lp = 16'(16'h0100 + $urandom_range(16'h7000));
      wr(tmr_pair_pkg::IDX_LOWER_PERIOD, lp);
      wr(tmr_pair_pkg::IDX_UPPER_PERIOD, 16'h0001);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0008);
      wr(tmr_pair_pkg::IDX_UPPER_HOLDING, 16'h0001);
      wr(tmr_pair_pkg::IDX_LOWER_COUNT, lp - 16'd40);
      rdchk("upper loaded", tmr_pair_pkg::IDX_UPPER_COUNT, 16'h0001);
      wr(tmr_pair_pkg::IDX_UPPER_HOLDING, 16'h0000);
      rdchk("lower word", tmr_pair_pkg::IDX_LOWER_COUNT, lp - 16'd40);
      rdchk("holding latch", tmr_pair_pkg::IDX_UPPER_HOLDING, 16'h0001);
      wr(tmr_pair_pkg::IDX_IRQ_ENABLE, 16'h0080);
      // slow upper prescale must not matter while joined
      wr(tmr_pair_pkg::IDX_UPPER_CONTROL, 16'h8030);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h8008);
      wait_for(adc_trigger, 80, "32-bit trigger");
      wait_for(irq, 3, "32-bit irq");
      rdchk("32-bit flag", tmr_pair_pkg::IDX_IRQ_FLAG, 16'h0080);
      xfer(1'b0, tmr_pair_pkg::IDX_LOWER_COUNT, 16'h0000);
      check("wrapped", {31'h0, rd[15:0] < 16'd100}, 32'h1);
      rdchk("upper wrapped", tmr_pair_pkg::IDX_UPPER_HOLDING, 16'h0000);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h0008);
      wr(tmr_pair_pkg::IDX_IRQ_FLAG, 16'h00C0);
      wr(tmr_pair_pkg::IDX_LOWER_CONTROL, 16'h8048);
      check("irq before gate", {31'h0, irq}, 32'h0);
      gate_clk_in <= 1'b1;
      repeat (10) @(posedge pclk);
      gate_clk_in <= 1'b0;
      wait_for(irq, 6, "gate fall irq");
      rdchk("gate flag", tmr_pair_pkg::IDX_IRQ_FLAG, 16'h0080);
      print_verdict();
   end
endmodule

bind tmr_pair tmr_pair_chk chk (
   .pclk        (pclk),
   .presetn     (presetn),
   .apb_req     (apb_req),
   .prdata      (prdata),
   .pready      (pready),
   .pslverr     (pslverr),
   .cpu_sleep   (cpu_sleep),
   .adc_trigger (adc_trigger),
   .irq         (irq)
);

`default_nettype wire
